// ==== hdl/pktmem_arb_consts.vh ====
// constants shared by the packet memory arbiter and its byte fifo
// assumes inclusion by bare name from the hdl folder
`ifndef PKTMEM_ARB_CONSTS_VH
`define PKTMEM_ARB_CONSTS_VH
`define FIFO_DEPTH_DEF  4
`define FIFO_CNT_W      3
`define ADDR_W_DEF      11
`define PKT_W_DEF       6
`define CNT_ZERO        3'h0
`define CNT_ONE         3'h1
`define CNT_TWO         3'h2
`define CNT_THREE       3'h3
`define MEM_IDLE        2'h0
`define MEM_HOST        2'h1
`define MEM_RX          2'h2
`define MEM_TX          2'h3
`endif

// ==== hdl/byte_fifo_mem.v ====
// small byte storage for the host data fifo, registered read data
// assumes the caller never writes a full slot and supplies both read pointers
`timescale 1ns/1ps
`default_nettype none
module byte_fifo_mem #(
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire          clk_sys,
  input  wire          we0,
  input  wire [AW-1:0] wa0,
  input  wire [7:0]    wd0,
  input  wire          we1,
  input  wire [AW-1:0] wa1,
  input  wire [7:0]    wd1,
  input  wire [AW-1:0] ra0,
  input  wire [AW-1:0] ra1,
  output reg  [7:0]    rd0,
  output reg  [7:0]    rd1
);
  reg [7:0] mem [0:DEPTH-1];

  // two write lanes so a word lands in one cycle
  always @(posedge clk_sys) begin
    if (we0) begin
      mem[wa0] <= wd0;
    end
    if (we1) begin
      mem[wa1] <= wd1;
    end
  end

  // registered reads; a slot written on this edge is forwarded,
  // else a byte queued on that same edge would be read stale
  always @(posedge clk_sys) begin
    if (we0 && (wa0 == ra0)) begin
      rd0 <= wd0;
    end else if (we1 && (wa1 == ra0)) begin
      rd0 <= wd1;
    end else begin
      rd0 <= mem[ra0];
    end
    if (we0 && (wa0 == ra1)) begin
      rd1 <= wd0;
    end else if (we1 && (wa1 == ra1)) begin
      rd1 <= wd1;
    end else begin
      rd1 <= mem[ra1];
    end
  end
endmodule
`default_nettype wire

// ==== hdl/host_packet_memory_arbiter.v ====
// host side fifo and packet memory arbiter
// assumes a one-cycle packet memory: grant means the access happens that cycle
// Operation
// - host strobes are accepted at once; ready is never negated
// - host write bytes go into fifo; host cycle ends immediately
// - host memory request is raised while the write fifo is not empty
// - byte or word cycle chosen from pointer lsb and fifo fill
// - loading a read pointer starts prefetch so a word is ready
// - further prefetch requested by number of bytes left in fifo
// - odd read pointer fetches one byte, then a word, three bytes held
// - a word read leaving one byte triggers another word fetch
// - odd write pointer stores first buffered byte as a byte cycle
// - even address with two or more bytes stores a word cycle
// - network cycles route that side's address and packet number
// - full duplex alternates receive and transmit requests
// - host access time never waits on memory; only cycle time grows
`timescale 1ns/1ps
`default_nettype none
`include "pktmem_arb_consts.vh"
module host_packet_memory_arbiter #(
  parameter AW    = `ADDR_W_DEF,
  parameter PW    = `PKT_W_DEF,
  parameter DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire          clk_sys,
  input  wire          srst,
  input  wire          ptr_load,
  input  wire          ptr_read,
  input  wire [AW-1:0] ptr_value,
  input  wire [PW-1:0] host_pkt,
  input  wire          host_wr,
  input  wire          host_rd,
  input  wire          host_word,
  input  wire [15:0]   host_wdata,
  output wire          host_ready,
  output reg  [15:0]   host_rdata,
  output wire          host_wr_full,
  input  wire          rx_req,
  input  wire [AW-1:0] rx_addr,
  input  wire [PW-1:0] rx_pkt,
  input  wire          tx_req,
  input  wire [AW-1:0] tx_addr,
  input  wire [PW-1:0] tx_pkt,
  input  wire          full_duplex,
  output reg           rx_grant,
  output reg           tx_grant,
  output reg           mem_en,
  output reg           mem_we,
  output reg           mem_word,
  output reg  [AW-1:0] mem_addr,
  output reg  [PW-1:0] mmu_pkt,
  output reg  [15:0]   mem_wdata,
  input  wire [15:0]   mem_rdata,
  output wire          host_mem_req
);
  localparam FAW = 2;
  reg  [2:0]    cnt_reg;
  reg  [FAW-1:0] wp_reg;
  reg  [FAW-1:0] rp_reg;
  reg  [AW-1:0] maddr_reg;
  reg           rd_mode_reg;
  reg           last_net_tx_reg;
  wire [7:0]    fo0;
  wire [7:0]    fo1;
  // byte counts in flight
  wire [2:0]    push_n;
  wire [2:0]    pop_n;
  reg           we0;
  reg           we1;
  reg  [7:0]    wd0;
  reg  [7:0]    wd1;
  reg  [1:0]    owner;
  wire          odd_ptr = maddr_reg[0];
  wire          net_req = rx_req | tx_req;
  reg           host_want;
  reg           host_word_cyc;

  // host never waits: accesses finish in the strobe cycle
  assign host_ready   = 1'b1;
  assign host_wr_full = (cnt_reg > (`CNT_THREE - {2'h0, host_word})) & ~rd_mode_reg;
  assign host_mem_req = host_want;

  // request: writes drain while not empty, reads refill at one byte or less, or at two with an odd address
  always @* begin
    host_want     = 1'b0;
    host_word_cyc = 1'b0;
    if (!rd_mode_reg) begin
      host_want     = (cnt_reg != `CNT_ZERO);
      host_word_cyc = ~odd_ptr & (cnt_reg >= `CNT_TWO);
    end else begin
      host_want     = (cnt_reg <= `CNT_ONE) | (cnt_reg == `CNT_TWO & odd_ptr);
      host_word_cyc = ~odd_ptr;
    end
  end

  // network wins over host; duplex alternates rx and tx
  always @* begin
    owner = `MEM_IDLE;
    if (rx_req & tx_req) begin
      owner = (full_duplex & ~last_net_tx_reg) ? `MEM_TX : `MEM_RX;
    end else if (rx_req) begin
      owner = `MEM_RX;
    end else if (tx_req) begin
      owner = `MEM_TX;
    end else if (~net_req & host_want) begin
      owner = `MEM_HOST;
    end
  end

  // memory port drive; route mmu fields to the granted side
  always @* begin
    mem_en    = owner != `MEM_IDLE;
    mem_we    = 1'b0;
    mem_word  = 1'b1;
    mem_addr  = maddr_reg;
    mmu_pkt   = host_pkt;
    mem_wdata = {fo1, fo0};
    rx_grant  = owner == `MEM_RX;
    tx_grant  = owner == `MEM_TX;
    case (owner)
      `MEM_RX: begin
        mem_addr = rx_addr;
        mmu_pkt  = rx_pkt;
      end
      `MEM_TX: begin
        mem_addr = tx_addr;
        mmu_pkt  = tx_pkt;
      end
      `MEM_HOST: begin
        mem_we   = ~rd_mode_reg;
        mem_word = host_word_cyc;
        if (!host_word_cyc) begin
          mem_wdata = {fo0, fo0};
        end
      end
      default: begin
        mem_en = 1'b0;
      end
    endcase
  end

  // fifo inputs: host writes or memory read data
  always @* begin
    we0 = 1'b0;
    we1 = 1'b0;
    wd0 = host_wdata[7:0];
    wd1 = host_wdata[15:8];
    if (rd_mode_reg) begin
      if (owner == `MEM_HOST) begin
        we0 = 1'b1;
        we1 = host_word_cyc;
        wd0 = (host_word_cyc | ~odd_ptr) ? mem_rdata[7:0] : mem_rdata[15:8];
        wd1 = mem_rdata[15:8];
      end
    end else if (host_wr & ~host_wr_full & ~ptr_load) begin
      we0 = 1'b1;
      we1 = host_word;
    end
  end

  assign push_n = {1'b0, we1, we0 & ~we1} ;
  assign pop_n  = (owner == `MEM_HOST & ~rd_mode_reg) ? (host_word_cyc ? `CNT_TWO : `CNT_ONE) :
                  (rd_mode_reg & host_rd & cnt_reg != `CNT_ZERO) ?
                  ((host_word & cnt_reg >= `CNT_TWO) ? `CNT_TWO : `CNT_ONE) : `CNT_ZERO;

  // fifo read data are registered, so address with next pointer
  wire [FAW-1:0] rp_reg_next_ra0 = rp_reg + pop_n[FAW-1:0];
  wire [FAW-1:0] rp_reg_next_ra1 = rp_reg + pop_n[FAW-1:0] + 2'h1;

  byte_fifo_mem #(.DEPTH(DEPTH), .AW(FAW)) u_fifo (
    .clk_sys (clk_sys),
    .we0     (we0),
    .wa0     (wp_reg),
    .wd0     (wd0),
    .we1     (we1),
    .wa1     (wp_reg + 2'h1),
    .wd1     (wd1),
    .ra0     (rp_reg_next_ra0),
    .ra1     (rp_reg_next_ra1),
    .rd0     (fo0),
    .rd1     (fo1)
  );

  // pointers, count and memory address; pointer load flushes the fifo
  always @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg         <= `CNT_ZERO;
      wp_reg          <= 2'h0;
      rp_reg          <= 2'h0;
      maddr_reg       <= {AW{1'b0}};
      rd_mode_reg     <= 1'b0;
      last_net_tx_reg <= 1'b0;
      host_rdata      <= 16'h0000;
    end else begin
      if (rx_grant | tx_grant) begin
        last_net_tx_reg <= tx_grant;
      end
      if (ptr_load) begin
        cnt_reg     <= `CNT_ZERO;
        wp_reg      <= 2'h0;
        rp_reg      <= 2'h0;
        maddr_reg   <= ptr_value;
        rd_mode_reg <= ptr_read;
      end else begin
        cnt_reg <= cnt_reg + push_n - pop_n;
        wp_reg  <= wp_reg + push_n[FAW-1:0];
        rp_reg  <= rp_reg + pop_n[FAW-1:0];
        if (owner == `MEM_HOST) begin
          maddr_reg <= maddr_reg + (host_word_cyc ? {{(AW-2){1'b0}}, 2'h2} :
                                                    {{(AW-1){1'b0}}, 1'b1});
        end
      end
      if (rd_mode_reg & host_rd) begin
        host_rdata <= {fo1, fo0};
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/pm_arb_monitor.sv ====
// port assertions for the packet memory arbiter
// assumes a bind onto host_packet_memory_arbiter
`timescale 1ns/1ps
`default_nettype none
module pm_arb_monitor #(
  parameter AW = 11,
  parameter PW = 6
) (
  input wire logic          clk_sys,
  input wire logic          srst,
  input wire logic          ptr_load,
  input wire logic          ptr_read,
  input wire logic [AW-1:0] ptr_value,
  input wire logic          host_wr,
  input wire logic          host_word,
  input wire logic          host_ready,
  input wire logic          rx_req,
  input wire logic [AW-1:0] rx_addr,
  input wire logic [PW-1:0] rx_pkt,
  input wire logic          tx_req,
  input wire logic          full_duplex,
  input wire logic          rx_grant,
  input wire logic          tx_grant,
  input wire logic          mem_en,
  input wire logic          mem_we,
  input wire logic          mem_word,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [PW-1:0] mmu_pkt
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // network traffic always outranks the host fifo
  wire net_req = rx_req | tx_req;
  AST_READY: assert property (host_ready)
    else $error("ready negated");
  AST_RX_ROUTE: assert property (rx_grant |-> mem_en && mem_addr == rx_addr && mmu_pkt == rx_pkt)
    else $error("rx cycle misrouted");
  AST_ONE_GRANT: assert property (!(rx_grant && tx_grant))
    else $error("two grants");
  AST_ALT: assert property (full_duplex && rx_grant ##1 full_duplex && rx_req && tx_req |-> tx_grant)
    else $error("no alternation");
  AST_NET_FIRST: assert property (net_req |-> rx_grant || tx_grant)
    else $error("net request idle");
  AST_ODD_WR: assert property (ptr_load && !ptr_read && ptr_value[0] ##1 host_wr && host_word
    ##1 !net_req |-> mem_we && !mem_word && mem_addr == $past(ptr_value, 2))
    else $error("odd byte store missing");
  AST_EVEN_WR: assert property (ptr_load && !ptr_read && !ptr_value[0] ##1 host_wr && host_word
    ##1 !net_req |-> mem_we && mem_word && mem_addr == $past(ptr_value, 2))
    else $error("even word store missing");
  AST_ODD_RD: assert property (ptr_load && ptr_read && ptr_value[0] && !net_req
    |-> ##[1:3] mem_en && !mem_we && !mem_word)
    else $error("odd prefetch byte missing");
  cover property (rx_grant ##1 tx_grant);
  cover property (mem_we && mem_word);
  cover property (mem_en && !mem_we && mem_word);
endmodule
`default_nettype wire

// ==== tb/pktmem_model.sv ====
// one-cycle packet memory behind the arbiter
// assumes byte lanes by address bit 0, byte cycles on their own lane
`timescale 1ns/1ps
`default_nettype none
module pktmem_model (
  input wire logic        clk_sys,
  input wire logic        mem_en,
  input wire logic        mem_we,
  input wire logic        mem_word,
  input wire logic [10:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output wire logic [15:0] mem_rdata
);
  logic [7:0] mem [0:2047];
  wire [10:0] ev = {mem_addr[10:1], 1'b0};
  wire [10:0] od = {mem_addr[10:1], 1'b1};
  // idle bus shows inverted data so a stale read cannot pass
  assign mem_rdata = mem_en ? {mem[od], mem[ev]} : ~{mem[od], mem[ev]};
  initial for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h3C;
  always @(posedge clk_sys) begin
    if (mem_en && mem_we && mem_word) begin
      mem[ev] <= mem_wdata[7:0];
      mem[od] <= mem_wdata[15:8];
    end else if (mem_en && mem_we)
      mem[mem_addr] <= mem_addr[0] ? mem_wdata[15:8] : mem_wdata[7:0];
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the packet memory arbiter
// assumes the memory model and monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); \
  end \
end
module testbench;
  logic clk_sys = 0, srst = 1, ptr_load = 0, ptr_read = 0, host_wr = 0, host_rd = 0;
  logic host_word = 1, rx_req = 0, tx_req = 0, full_duplex = 0;
  logic [10:0] ptr_value = 0, rx_addr = 11'h155, tx_addr = 11'h0AA;
  logic [5:0] host_pkt = 6'h07, rx_pkt = 6'h2A, tx_pkt = 6'h15;
  logic [15:0] host_wdata = 0;
  wire logic [15:0] host_rdata, mem_wdata, mem_rdata;
  wire logic [10:0] mem_addr;
  wire logic [5:0] mmu_pkt;
  wire logic host_ready, host_wr_full, rx_grant, tx_grant, mem_en, mem_we, mem_word, host_mem_req;
  int err_count = 0, checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  host_packet_memory_arbiter host_packet_memory_arbiter_inst (.clk_sys, .srst, .ptr_load,
    .ptr_read, .ptr_value, .host_pkt, .host_wr, .host_rd, .host_word, .host_wdata,
    .host_ready, .host_rdata, .host_wr_full, .rx_req, .rx_addr, .rx_pkt, .tx_req, .tx_addr,
    .tx_pkt, .full_duplex, .rx_grant, .tx_grant, .mem_en, .mem_we, .mem_word, .mem_addr,
    .mmu_pkt, .mem_wdata, .mem_rdata, .host_mem_req);
  pktmem_model pktmem_model_inst (.clk_sys, .mem_en, .mem_we, .mem_word, .mem_addr,
    .mem_wdata, .mem_rdata);
  // one host bus cycle per falling edge
  task step(input ld, input wr, input rd, input [10:0] p, input [15:0] d);
    ptr_load = ld;
    host_wr = wr;
    host_rd = rd;
    ptr_value = p;
    host_wdata = d;
    @(negedge clk_sys);
  endtask
  // posted writes land later, so poll the memory under a bound
  task expect_mem(input [10:0] a, input [7:0] v);
    int i;
    for (i = 0; i < 20 && pktmem_model_inst.mem[a] !== v; i++) @(negedge clk_sys);
    `CHECK("mem", v, pktmem_model_inst.mem[a])
    if (i == 20) print_verdict;
  endtask
  task print_verdict;
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_write;
    ptr_read = 0;
    step(1, 0, 0, 11'h101, 0);
    step(0, 1, 0, 0, 16'hBBAA);
    `CHECK("host_mem_req", 1'b1, host_mem_req)
    step(0, 1, 0, 0, 16'hDDCC);
    step(0, 0, 0, 0, 0);
    expect_mem(11'h101, 8'hAA);
    expect_mem(11'h103, 8'hCC);
    `CHECK("mem", 8'hBB, pktmem_model_inst.mem[11'h102])
    step(1, 0, 0, 11'h110, 0);
    step(0, 1, 0, 0, 16'h2211);
    step(0, 0, 0, 0, 0);
    expect_mem(11'h111, 8'h22);
    `CHECK("mem", 8'h11, pktmem_model_inst.mem[11'h110])
    `CHECK("host_mem_req", 1'b0, host_mem_req)
  endtask
  // network holds memory so the fifo fills; the extra write is dropped
  task t_full;
    ptr_read = 0;
    rx_req = 1;
    step(1, 0, 0, 11'h120, 0);
    step(0, 1, 0, 0, 16'h5544);
    step(0, 1, 0, 0, 16'h7766);
    `CHECK("host_wr_full", 1'b1, host_wr_full)
    step(0, 1, 0, 0, 16'h9988);
    rx_req = 0;
    step(0, 0, 0, 0, 0);
    expect_mem(11'h121, 8'h55);
    expect_mem(11'h123, 8'h77);
    `CHECK("mem", 8'h44, pktmem_model_inst.mem[11'h120])
    `CHECK("mem", 8'h18, pktmem_model_inst.mem[11'h124])
  endtask
  task t_read;
    ptr_read = 1;
    step(1, 0, 0, 11'h201, 0);
    repeat (4) step(0, 0, 0, 0, 0);
    step(0, 0, 1, 0, 0);
    step(0, 0, 0, 0, 0);
    `CHECK("rdata", 16'h3E3D, host_rdata)
    step(0, 0, 1, 0, 0);
    step(0, 0, 0, 0, 0);
    `CHECK("rdata", 16'h383F, host_rdata)
  endtask
  task t_net;
    logic prev;
    rx_req = 1;
    #1;
    `CHECK("rx_grant", 1'b1, rx_grant)
    `CHECK("mem_addr", 11'h155, mem_addr)
    `CHECK("mmu_pkt", 6'h2A, mmu_pkt)
    @(negedge clk_sys);
    tx_req = 1;
    full_duplex = 1;
    #1 prev = rx_grant;
    `CHECK("tx_grant", 1'b1, tx_grant)
    `CHECK("mem_addr", 11'h0AA, mem_addr)
    `CHECK("mmu_pkt", 6'h15, mmu_pkt)
    repeat (4) begin
      @(negedge clk_sys);
      `CHECK("alternate", ~prev, rx_grant)
      prev = rx_grant;
    end
    `CHECK("ready", 1'b1, host_ready)
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    srst = 0;
    t_write;
    t_full;
    t_read;
    t_net;
    print_verdict;
  end
endmodule
bind host_packet_memory_arbiter pm_arb_monitor #(.AW(AW), .PW(PW)) pm_arb_monitor_inst (
  .clk_sys, .srst, .ptr_load, .ptr_read, .ptr_value, .host_wr, .host_word, .host_ready,
  .rx_req, .rx_addr, .rx_pkt, .tx_req, .full_duplex, .rx_grant, .tx_grant, .mem_en,
  .mem_we, .mem_word, .mem_addr, .mmu_pkt);
`default_nettype wire
